// ### cit_pkg.sv
// Contract
// - repeat prefixes are one byte, two clocks, no data transfer
// - near exit: one transfer, 8 clocks short form, 12 with discard
// - far exit: two transfers, 18 clocks short form, 17 with discard
// - shifts: 2, 8+4/bit, 15+addr, 20+addr+4/bit; memory two transfers
// - flags from high accumulator: one byte, 4 clocks, no transfer
// - scan 15 clocks one transfer; repeated 9+15 per rep, one each
// - subtract with borrow: 3, 9+addr, 16+addr, 4, 17+addr clocks
// - segment override: one byte, adds 2 clocks, no transfer
// - 16-bit bus: odd-address word transfer adds four clocks
// - 8-bit bus: every word transfer adds four clocks
package cit_pkg;
   typedef enum logic [4:0] {
      CIT_LOOP_EQ, CIT_LOOP_NE, CIT_EXIT_NEAR, CIT_EXIT_NEAR_POP,
      CIT_EXIT_FAR, CIT_EXIT_FAR_POP, CIT_SH_REG_1, CIT_SH_REG_CNT,
      CIT_SH_MEM_1, CIT_SH_MEM_CNT, CIT_FLAGS_HI, CIT_SCAN, CIT_SCAN_REP,
      CIT_SWB_RR, CIT_SWB_RM, CIT_SWB_MR, CIT_SWB_AI, CIT_SWB_RI,
      CIT_SWB_MI, CIT_SEG_OVR
   } cit_op_e;
   localparam logic [7:0] CIT_T_PREFIX     = 8'h02;
   localparam logic [7:0] CIT_T_NEAR       = 8'h08;
   localparam logic [7:0] CIT_T_NEAR_POP   = 8'h0C;
   localparam logic [7:0] CIT_T_FAR        = 8'h12;
   localparam logic [7:0] CIT_T_FAR_POP    = 8'h11;
   localparam logic [7:0] CIT_T_SH_REG_1   = 8'h02;
   localparam logic [7:0] CIT_T_SH_REG_CNT = 8'h08;
   localparam logic [7:0] CIT_T_SH_MEM_1   = 8'h0F;
   localparam logic [7:0] CIT_T_SH_MEM_CNT = 8'h14;
   localparam logic [7:0] CIT_T_PER_BIT    = 8'h04;
   localparam logic [7:0] CIT_T_FLAGS_HI   = 8'h04;
   localparam logic [7:0] CIT_T_SCAN       = 8'h0F;
   localparam logic [7:0] CIT_T_SCAN_REP   = 8'h09;
   localparam logic [7:0] CIT_T_PER_REP    = 8'h0F;
   localparam logic [7:0] CIT_T_SWB_RR     = 8'h03;
   localparam logic [7:0] CIT_T_SWB_RM     = 8'h09;
   localparam logic [7:0] CIT_T_SWB_MR     = 8'h10;
   localparam logic [7:0] CIT_T_SWB_AI     = 8'h04;
   localparam logic [7:0] CIT_T_SWB_MI     = 8'h11;
   localparam logic [7:0] CIT_T_WORD_PEN   = 8'h04;
endpackage

// ### cit_base_rom.sv
`timescale 1ns/100ps
module cit_base_rom
   import cit_pkg::*;
(
   // request
   input  wire cit_op_e    i_op,
   // answer
   output logic [7:0]      o_base,
   output logic [2:0]      o_bytes,
   output logic [1:0]      o_xfers,
   output logic            o_addr_time,
   output logic            o_per_bit,
   output logic            o_per_rep
);
   always_comb begin
      o_base    = 8'h00;
      o_bytes   = 3'h1;
      o_xfers   = 2'h0;
      o_addr_time = 1'b0;
      o_per_bit = 1'b0;
      o_per_rep = 1'b0;
      unique case (i_op)
         CIT_LOOP_EQ, CIT_LOOP_NE: o_base = CIT_T_PREFIX;
         CIT_EXIT_NEAR: begin
            o_base = CIT_T_NEAR;
            o_xfers = 2'h1;
         end
         CIT_EXIT_NEAR_POP: begin
            o_base = CIT_T_NEAR_POP;
            o_xfers = 2'h1;
            o_bytes = 3'h3;
         end
         CIT_EXIT_FAR: begin
            o_base = CIT_T_FAR;
            o_xfers = 2'h2;
         end
         CIT_EXIT_FAR_POP: begin
            o_base = CIT_T_FAR_POP;
            o_xfers = 2'h2;
            o_bytes = 3'h3;
         end
         CIT_SH_REG_1: begin
            o_base = CIT_T_SH_REG_1;
            o_bytes = 3'h2;
         end
         CIT_SH_REG_CNT: begin
            o_base = CIT_T_SH_REG_CNT;
            o_bytes = 3'h2;
            o_per_bit = 1'b1;
         end
         CIT_SH_MEM_1: begin
            o_base = CIT_T_SH_MEM_1;
            o_bytes = 3'h2;
            o_xfers = 2'h2;
            o_addr_time = 1'b1;
         end
         CIT_SH_MEM_CNT: begin
            o_base = CIT_T_SH_MEM_CNT;
            o_bytes = 3'h2;
            o_xfers = 2'h2;
            o_addr_time = 1'b1;
            o_per_bit = 1'b1;
         end
         CIT_FLAGS_HI: o_base = CIT_T_FLAGS_HI;
         CIT_SCAN: begin
            o_base = CIT_T_SCAN;
            o_xfers = 2'h1;
         end
         CIT_SCAN_REP: begin
            o_base = CIT_T_SCAN_REP;
            o_xfers = 2'h1;
            o_per_rep = 1'b1;
         end
         CIT_SWB_RR: begin
            o_base = CIT_T_SWB_RR;
            o_bytes = 3'h2;
         end
         CIT_SWB_RM: begin
            o_base = CIT_T_SWB_RM;
            o_bytes = 3'h2;
            o_xfers = 2'h1;
            o_addr_time = 1'b1;
         end
         CIT_SWB_MR: begin
            o_base = CIT_T_SWB_MR;
            o_bytes = 3'h2;
            o_xfers = 2'h2;
            o_addr_time = 1'b1;
         end
         CIT_SWB_AI: begin
            o_base = CIT_T_SWB_AI;
            o_bytes = 3'h2;
         end
         CIT_SWB_RI: begin
            o_base = CIT_T_SWB_AI;
            o_bytes = 3'h3;
         end
         CIT_SWB_MI: begin
            o_base = CIT_T_SWB_MI;
            o_bytes = 3'h3;
            o_xfers = 2'h2;
            o_addr_time = 1'b1;
         end
         CIT_SEG_OVR: o_base = CIT_T_PREFIX;
         default: o_base = 8'h00;
      endcase
   end
endmodule

// ### cit_timer.sv
`timescale 1ns/100ps
module cit_timer
   import cit_pkg::*;
#(
   parameter int CNT_W = 16
)(
   // clock and reset
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_b,
   // request
   input  wire logic             i_start,
   input  wire logic [4:0]       i_op,
   input  wire logic [7:0]       i_addr_clocks,
   input  wire logic [7:0]       i_count,
   input  wire logic             i_word,
   input  wire logic             i_odd_addr,
   input  wire logic             i_bus8,
   // answer
   output logic                  o_valid,
   output logic [CNT_W-1:0]      o_clocks,
   output logic [2:0]            o_bytes,
   output logic [7:0]            o_xfers,
   output logic                  o_busy,
   output logic                  o_done
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0]       base;
   logic [2:0]       bytes;
   logic [1:0]       xf;
   logic             uses_addr;
   logic             per_bit;
   logic             per_rep;
   logic [CNT_W-1:0] total;
   logic [7:0]       nxf;
   logic [CNT_W-1:0] pen;
   logic             pen_on;

   cit_base_rom u_rom (
      .i_op      (cit_op_e'(i_op)),
      .o_base    (base),
      .o_bytes   (bytes),
      .o_xfers   (xf),
      .o_addr_time (uses_addr),
      .o_per_bit (per_bit),
      .o_per_rep (per_rep)
   );

   ////////////////////////////////////////////////////////////////////////
   logic             valid, next_valid, busy, next_busy, done, next_done;
   logic [CNT_W-1:0] clocks, next_clocks, left, next_left;
   logic [2:0]       bytes_q, next_bytes;
   logic [7:0]       xfers, next_xfers;

   always_comb begin
      // scan repeats make one transfer per repetition
      nxf = per_rep ? i_count : {6'h00, xf};
      total = CNT_W'(base);
      if (uses_addr) total = total + CNT_W'(i_addr_clocks);
      if (per_bit) total = total + CNT_W'(i_count) * CNT_W'(CIT_T_PER_BIT);
      if (per_rep) total = total + CNT_W'(i_count) * CNT_W'(CIT_T_PER_REP);
      // word penalty per transfer; 8-bit bus pays regardless of alignment
      pen_on = i_word && (i_bus8 || i_odd_addr);
      pen = pen_on ? CNT_W'(nxf) * CNT_W'(CIT_T_WORD_PEN) : '0;
      total = total + pen;
      next_valid  = 1'b0;
      next_done   = 1'b0;
      next_busy   = busy;
      next_left   = left;
      next_clocks = clocks;
      next_bytes  = bytes_q;
      next_xfers  = xfers;
      if (i_start && !busy) begin
         next_valid  = 1'b1;
         next_clocks = total;
         next_bytes  = bytes;
         next_xfers  = nxf;
         next_left   = total;
         next_busy   = 1'b1;
      end else if (busy) begin
         // counts down the modelled execution; done pulses in the cycle after its last clock
         next_left = left - CNT_W'(1);
         if (left <= CNT_W'(1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         valid   <= 1'b0;
         done    <= 1'b0;
         busy    <= 1'b0;
         left    <= '0;
         clocks  <= '0;
         bytes_q <= 3'h0;
         xfers   <= 8'h00;
      end else begin
         valid   <= next_valid;
         done    <= next_done;
         busy    <= next_busy;
         left    <= next_left;
         clocks  <= next_clocks;
         bytes_q <= next_bytes;
         xfers   <= next_xfers;
      end
   end

   assign o_valid  = valid;
   assign o_done   = done;
   assign o_busy   = busy;
   assign o_clocks = clocks;
   assign o_bytes  = bytes_q;
   assign o_xfers  = xfers;
endmodule

// ### cit_props.sv
`timescale 1ns/100ps
module cit_props #(
   parameter int CNT_W = 16
)(
   // clock and reset
   input wire logic             i_core_clk,
   input wire logic             i_rst_b,
   // request
   input wire logic             i_start,
   input wire logic [4:0]       i_op,
   input wire logic [7:0]       i_addr_clocks,
   input wire logic [7:0]       i_count,
   input wire logic             i_word,
   input wire logic             i_odd_addr,
   input wire logic             i_bus8,
   // answer
   input wire logic             o_valid,
   input wire logic [CNT_W-1:0] o_clocks,
   input wire logic [2:0]       o_bytes,
   input wire logic [7:0]       o_xfers,
   input wire logic             o_busy,
   input wire logic             o_done
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   wire take = i_start && !o_busy;
   ////////////////////////////////////////////////////////////////////////
   take_answer_a: assert property (take |=> o_valid && o_busy)
      else $error("no answer after take");
   valid_pulse_a: assert property (o_valid |=> !o_valid)
      else $error("valid longer than one cycle");
   done_idle_a: assert property (o_done |-> !o_busy && !o_valid)
      else $error("done while busy");
   // a start while counting must not restart the count
   start_refuse_a: assert property (o_busy && !o_done |=> !o_valid)
      else $error("start accepted while busy");
   borrow_reg_a: assert property (
      take && i_op == 5'h0D |=> o_clocks == 3 ##3 o_done)
      else $error("register subtract timing wrong");
   rep_prefix_a: assert property (
      take && i_op <= 5'h01 |=> o_clocks == 2 && o_bytes == 1
      && o_xfers == 0) else $error("repeat prefix wrong");
   flags_load_a: assert property (
      take && i_op == 5'h0A |=> o_clocks == 4 && o_xfers == 0)
      else $error("flags load wrong");
   seg_prefix_a: assert property (
      take && i_op == 5'h13 |=> o_clocks == 2 && o_xfers == 0)
      else $error("segment prefix wrong");
   near_exit_a: assert property (
      take && i_op == 5'h02 && !i_word |=> o_clocks == 8 && o_xfers == 1)
      else $error("near exit wrong");
   far_exit_a: assert property (
      take && i_op == 5'h04 && !i_word |=> o_clocks == 18 && o_xfers == 2)
      else $error("far exit wrong");
   narrow_pen_a: assert property (
      take && i_op == 5'h05 && i_word && i_bus8 |=> o_clocks == 25)
      else $error("narrow bus penalty wrong");
endmodule

bind cit_timer cit_props #(.CNT_W(CNT_W)) u_cit_props (.i_core_clk,
   .i_rst_b, .i_start, .i_op, .i_addr_clocks, .i_count, .i_word, .i_odd_addr,
   .i_bus8, .o_valid, .o_clocks, .o_bytes, .o_xfers, .o_busy, .o_done);

// ### cit_mem_model.sv
`timescale 1ns/100ps
// memory side: bus width variant and operand alignment
module cit_mem_model (
   // bus setup
   input  wire logic        i_bus8_sel,
   input  wire logic [15:0] i_addr,
   // seen by the timer
   output logic             o_bus8,
   output logic             o_odd_addr
);
   assign o_bus8     = i_bus8_sel;
   assign o_odd_addr = i_addr[0];
endmodule

// ### tb_cit_timer.sv
`timescale 1ns/100ps
module tb_cit_timer;
   logic        i_core_clk, i_rst_b, i_start, i_word, i_odd_addr, i_bus8;
   logic        o_valid, o_busy, o_done, sel8;
   logic [4:0]  i_op;
   logic [7:0]  i_addr_clocks, i_count, o_xfers;
   logic [15:0] addr, o_clocks;
   logic [2:0]  o_bytes;
   int n_mismatch, n_checks, seed, t, ec, c, x, w;
   int qc[$], qb[$], qx[$];
   int bt[20] = '{2,2,8,12,18,17,2,8,15,20,4,15,9,3,9,16,4,4,17,2};
   int by[20] = '{1,1,1,3,1,3,2,2,2,2,1,1,1,2,2,2,2,3,3,1};
   int xt[20] = '{0,0,1,1,2,2,0,0,2,2,0,1,0,0,1,2,0,0,2,0};
   cit_timer #(.CNT_W(16)) u_cit_timer (.i_core_clk, .i_rst_b, .i_start,
      .i_op, .i_addr_clocks, .i_count, .i_word, .i_odd_addr, .i_bus8,
      .o_valid, .o_clocks, .o_bytes, .o_xfers, .o_busy, .o_done);
   cit_mem_model u_cit_mem_model (.i_bus8_sel(sel8), .i_addr(addr),
      .o_bus8(i_bus8), .o_odd_addr(i_odd_addr));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_core_clk = 0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // p: 0 byte operand, 1 narrow bus, 2 odd word, 3 even word
   task go(input int op, input int p, input bit rf);
      @(posedge i_core_clk);
      #1;
      i_op = op;
      i_addr_clocks = $random(seed) & 15;
      i_count = $unsigned($random(seed)) % 9;
      i_word = p != 0;
      sel8 = p == 1;
      // alignment stays random where it must not matter
      addr = 16'($random(seed));
      if (p >= 2) addr[0] = p == 2;
      x = op == 12 ? i_count : xt[op];
      c = bt[op] + (op inside {8, 9, 14, 15, 18} ? i_addr_clocks : 0);
      c += op inside {7, 9} ? 4 * i_count : 0;
      c += op == 12 ? 15 * i_count : 0;
      c += (p != 0 && p != 3) ? 4 * x : 0;
      qc.push_back(c);
      qb.push_back(by[op]);
      qx.push_back(x);
      i_start = 1;
      @(posedge i_core_clk);
      #1 i_start = rf;
      i_op = 0;
      @(posedge i_core_clk);
      #1 i_start = 0;
      for (w = 0; w < 400 && o_done !== 1'b1; w++) @(posedge i_core_clk) #1;
      if (w == 400) chk(0, 1);
   endtask
   always @(posedge i_core_clk) if (i_rst_b) begin
      if (o_valid) begin
         if (qc.size() == 0) chk(o_valid, 0);
         else begin
            ec = qc.pop_front();
            chk(o_clocks, ec);
            chk(o_bytes, qb.pop_front());
            x = qx.pop_front();
            chk(o_xfers, x);
            t = 0;
         end
      end else t++;
      if (o_done) chk(t, ec);
   end
   initial begin
      #1000000;
      n_mismatch++;
      conclude;
   end
   initial begin
      seed = 88168;
      {i_rst_b, i_start, i_op, i_addr_clocks, i_count, i_word, sel8} = 0;
      addr = 0;
      repeat (8) @(posedge i_core_clk);
      #1 i_rst_b = 1;
      for (int k = 0; k < 80; k++) go(k % 20, k / 20, 0);
      $display("test all forms done");
      go(2, 0, 1);
      go(13, 2, 1);
      // let the monitor see the last done pulse before the verdict
      @(posedge i_core_clk) #1;
      $display("test refused start done");
      conclude;
   end
endmodule
